// >>> shared/uart_irlin_pkg.sv
// Constants shared by the infrared and LIN receive extension of the UART.
// Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
package uart_irlin_pkg;

  // Register byte offsets
  localparam logic [3:0] MODE_OFS   = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;
  localparam logic [3:0] RATE_OFS   = 4'h8;
  localparam logic [3:0] RXDATA_OFS = 4'hC;

  // Mode control register fields
  localparam int MODE_ENABLE_BIT = 15;
  localparam int MODE_IRDA_BIT   = 12;
  localparam int MODE_PINS_HI    = 9;
  localparam int MODE_PINS_LO    = 8;
  localparam int MODE_WAKE_BIT   = 7;
  localparam int MODE_ABD_BIT    = 5;
  localparam int MODE_HSPD_BIT   = 3;

  // Status control register fields
  localparam int STAT_POL_BIT   = 14;
  localparam int STAT_FRAMING_ERROR_FLAG_BIT  = 2;
  localparam int STAT_AVAIL_BIT = 0;

  // Reset values
  localparam logic [15:0] MODE_RESET = 16'h0000;
  localparam logic [15:0] RATE_RESET = 16'h0000;

  // Pin usage code that routes the 16x clock out
  localparam logic [1:0] PINS_BAUD_CLOCK = 2'h3;

  // Infrared timing in 16x ticks
  localparam logic [3:0] IR_PULSE_FIRST = 4'h7;
  localparam logic [3:0] IR_PULSE_LAST  = 4'h9;
  localparam logic [4:0] IR_LOW_TICKS   = 5'h10;

  // Receiver majority vote samples around the bit centre
  localparam logic [3:0] VOTE_FIRST = 4'h7;
  localparam logic [3:0] VOTE_LAST  = 4'h9;
  localparam logic [3:0] BIT_END    = 4'hF;

  // Auto rate: fifth rising edge ends eight bits of 32 half ticks
  localparam logic [2:0] ABD_LAST_EDGE = 3'h4;
  localparam int         ABD_SHIFT     = 8;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_STOP,
    RX_HOLD,
    RX_ABD
  } rx_state_t;

endpackage

// >>> hw/ir_pulse_encoder.sv
// Infrared pulse encoder: one data bit per sixteen 16x ticks.
// Assumes the bit phase comes from the top's shared tick counter.
`timescale 1ns/1ns
`default_nettype none
module ir_pulse_encoder
  import uart_irlin_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rstn_in,
  input  wire logic       tick_in,
  input  wire logic [3:0] phase_in,
  input  wire logic       bit_in,
  output logic            pulse_out
);

  logic       bit_r;
  logic       bit_nxt;
  logic       pulse_r;
  logic       pulse_nxt;
  logic [3:0] next_ph;
  logic       cur_bit;

  // Bit latched at the end of phase 0 so a late core change is caught
  always_comb
  begin
    next_ph   = phase_in + 4'h1;
    cur_bit   = (phase_in == 4'h0) ? bit_in : bit_r;
    bit_nxt   = bit_r;
    pulse_nxt = pulse_r;
    if (tick_in)
    begin
      bit_nxt   = cur_bit;
      // Ones stay low; zeros pulse high in ticks 7 to 9
      pulse_nxt = !cur_bit && (next_ph >= IR_PULSE_FIRST)
                  && (next_ph <= IR_PULSE_LAST);
    end
  end

  // State registers
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      bit_r   <= 1'b1;
      pulse_r <= 1'b0;
    end
    else
    begin
      bit_r   <= bit_nxt;
      pulse_r <= pulse_nxt;
    end
  end

  assign pulse_out = pulse_r;

endmodule
`default_nettype wire

// >>> hw/ir_pulse_decoder.sv
// Infrared pulse decoder: falling edges stretch into 16-tick lows.
// Assumes the pin is synchronous to clk_in and ticks come from the top.
`timescale 1ns/1ns
`default_nettype none
module ir_pulse_decoder
  import uart_irlin_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic rstn_in,
  input  wire logic tick_in,
  input  wire logic pin_in,
  output logic      data_out
);

  logic       pin_q_r;
  logic       edge_r;
  logic       edge_nxt;
  logic [4:0] cnt_r;
  logic [4:0] cnt_nxt;
  logic       data_r;
  logic       data_nxt;

  // Edge held until the next tick, so it is resolved to one tick
  always_comb
  begin
    edge_nxt = edge_r | (pin_q_r & ~pin_in);
    cnt_nxt  = cnt_r;
    data_nxt = data_r;
    if (tick_in)
    begin
      if (edge_nxt)
      begin
        // A fresh edge restarts the full low interval
        cnt_nxt  = IR_LOW_TICKS - 5'h1;
        data_nxt = 1'b0;
        edge_nxt = 1'b0;
      end
      else if (cnt_r != 5'h0)
        cnt_nxt = cnt_r - 5'h1;
      else
        data_nxt = 1'b1;
    end
  end

  // State registers
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      pin_q_r <= 1'b1;
      edge_r  <= 1'b0;
      cnt_r   <= 5'h0;
      data_r  <= 1'b1;
    end
    else
    begin
      pin_q_r <= pin_in;
      edge_r  <= edge_nxt;
      cnt_r   <= cnt_nxt;
      data_r  <= data_nxt;
    end
  end

  assign data_out = data_r;

endmodule
`default_nettype wire

// >>> hw/uart_irlin_rx.sv
// Infrared codec, 16x clock output and LIN receive front end of a UART.
// Assumes an AXI4-Lite master and a core transmitter paced by the strobe.
//
// Decided for this implementation: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module uart_irlin_rx
  import uart_irlin_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  input  wire logic [3:0]  s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  input  wire logic [3:0]  s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  input  wire logic        serial_in_pin_in,
  output logic             serial_out_pin_out,
  output logic             baud_clock_out,
  input  wire logic        tx_bit_in,
  output logic             tx_bit_strobe_out,
  output logic             rx_stream_out,
  output logic             rx_wake_event_out
);
  import uart_irlin_pkg::*;

  logic [15:0] mode_r, mode_nxt, rate_r, rate_nxt;
  logic        pol_r, pol_nxt, framing_error_flag_r, framing_error_flag_nxt, avail_r, avail_nxt;
  logic [7:0]  rxdata_r, rxdata_nxt;
  logic        aw_r, aw_nxt, w_r, w_nxt, b_r, b_nxt, r_r, r_nxt;
  logic [3:0]  awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
  logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [15:0] div_r, div_nxt;
  logic        half_ph_r, half_ph_nxt, bclk_r, bclk_nxt;
  logic [3:0]  tx_ph_r, tx_ph_nxt;
  logic        strobe_r, strobe_nxt, sout_r, sout_nxt, stream_q_r;
  logic        rxs_r, wake_evt_r, wake_evt_nxt;
  rx_state_t   st_r, st_nxt;
  logic [3:0]  tcnt_r, tcnt_nxt;
  logic [2:0]  bidx_r, bidx_nxt, ecnt_r, ecnt_nxt;
  logic [1:0]  ones_r, ones_nxt;
  logic [7:0]  shift_r, shift_nxt;
  logic [23:0] abd_r, abd_nxt;
  logic        half, tick, enabled, ir_en, stream, fall, rise, bitval;
  logic        hw_wake_clr, hw_abd_clr, hw_rate_ld, hw_framing_error_flag_set, hw_avail;
  logic        wr_go, rd_rx;
  logic [15:0] hw_rate;
  logic        enc_pulse, dec_data;

  assign enabled = mode_r[MODE_ENABLE_BIT];
  assign ir_en   = mode_r[MODE_IRDA_BIT];

  // Shared 16x tick: half ticks also pace the clock output pin
  always_comb
  begin
    half        = enabled && (div_r >= rate_r); // Safe if rate shrinks
    tick        = half && half_ph_r;
    div_nxt     = (!enabled || half) ? 16'h0000 : div_r + 16'h0001;
    half_ph_nxt = enabled ? (half_ph_r ^ half) : 1'b0;
    bclk_nxt    = 1'b0;
    if (enabled && mode_r[MODE_PINS_HI:MODE_PINS_LO] == PINS_BAUD_CLOCK)
      bclk_nxt = bclk_r ^ half;
    tx_ph_nxt   = tx_ph_r + {3'h0, tick};
    strobe_nxt  = tick && (tx_ph_r == BIT_END);
  end

  ir_pulse_encoder u_enc (
    .clk_in    (clk_in),
    .rstn_in   (rstn_in),
    .tick_in   (tick),
    .phase_in  (tx_ph_r),
    .bit_in    (tx_bit_in),
    .pulse_out (enc_pulse)
  );

  ir_pulse_decoder u_dec (
    .clk_in   (clk_in),
    .rstn_in  (rstn_in),
    .tick_in  (tick),
    .pin_in   (serial_in_pin_in),
    .data_out (dec_data)
  );

  // Pin routing; polarity only flips the encoded train
  always_comb
  begin
    sout_nxt = ir_en ? (enc_pulse ^ pol_r) : tx_bit_in;
    stream   = ir_en ? dec_data : serial_in_pin_in;
    fall     = stream_q_r & ~stream;
    rise     = ~stream_q_r & stream;
  end

  // Receiver and auto rate measurement
  always_comb
  begin
    st_nxt       = st_r;
    tcnt_nxt     = tcnt_r;
    bidx_nxt     = bidx_r;
    ones_nxt     = ones_r;
    shift_nxt    = shift_r;
    ecnt_nxt     = ecnt_r;
    abd_nxt      = abd_r;
    wake_evt_nxt = 1'b0;
    hw_wake_clr  = 1'b0;
    hw_abd_clr   = 1'b0;
    hw_rate_ld   = 1'b0;
    hw_framing_error_flag_set  = 1'b0;
    hw_avail     = 1'b0;
    hw_rate      = abd_r[ABD_SHIFT +: 16] - 16'h0001;
    bitval       = ones_r[1] | (ones_r[0] & stream & tcnt_r == BIT_END);
    if ((st_r == RX_START || st_r == RX_DATA || st_r == RX_STOP) && tick)
    begin
      tcnt_nxt = tcnt_r + 4'h1;
      if (tcnt_r >= VOTE_FIRST && tcnt_r <= VOTE_LAST && stream)
        ones_nxt = ones_r + 2'h1;
    end
    case (st_r)
      RX_IDLE:
      begin
        // Auto rate waits while wake is armed, so it follows the break
        if (mode_r[MODE_ABD_BIT] && !mode_r[MODE_WAKE_BIT])
        begin
          st_nxt   = RX_ABD;
          ecnt_nxt = 3'h0;
        end
        else if (fall)
        begin
          wake_evt_nxt = mode_r[MODE_WAKE_BIT];
          st_nxt       = RX_START;
          tcnt_nxt     = 4'h0;
          ones_nxt     = 2'h0;
          bidx_nxt     = 3'h0;
        end
      end
      RX_START, RX_DATA, RX_STOP:
      begin
        if (tick && tcnt_r == BIT_END)
        begin
          // Two of three centre samples decide the bit
          ones_nxt = 2'h0;
          bitval   = (ones_r == 2'h2) || (ones_r == 2'h3);
          if (st_r == RX_START)
            st_nxt = bitval ? RX_IDLE : RX_DATA;
          else if (st_r == RX_DATA)
          begin
            shift_nxt = {bitval, shift_r[7:1]};
            bidx_nxt  = bidx_r + 3'h1;
            if (bidx_r == 3'h7)
              st_nxt = RX_STOP;
          end
          else if (bitval)
          begin
            hw_avail = 1'b1;
            st_nxt   = RX_IDLE;
          end
          else
          begin
            hw_framing_error_flag_set = 1'b1;
            st_nxt      = RX_HOLD;
          end
        end
      end
      RX_HOLD:
      begin
        // Line must return high before any new start bit
        if (stream)
        begin
          hw_wake_clr = 1'b1;
          st_nxt      = RX_IDLE;
        end
      end
      RX_ABD:
      begin
        abd_nxt = (ecnt_r != 3'h0) ? abd_r + 24'h000001 : 24'h000000;
        if (!mode_r[MODE_ABD_BIT])
          st_nxt = RX_IDLE;
        else if (rise)
        begin
          ecnt_nxt = ecnt_r + 3'h1;
          if (ecnt_r == ABD_LAST_EDGE)
          begin
            hw_rate_ld = 1'b1;
            hw_abd_clr = 1'b1;
            st_nxt     = RX_IDLE;
          end
        end
      end
      default:
        st_nxt = RX_IDLE;
    endcase
  end

  // AXI4-Lite slave; write address and data may come in either order
  always_comb
  begin
    aw_nxt     = aw_r | s_axi_awvalid_in;
    w_nxt      = w_r | s_axi_wvalid_in;
    awaddr_nxt = (!aw_r && s_axi_awvalid_in) ? s_axi_awaddr_in : awaddr_r;
    wdata_nxt  = (!w_r && s_axi_wvalid_in) ? s_axi_wdata_in : wdata_r;
    wr_go      = aw_r && w_r && !b_r;
    b_nxt      = b_r ? !s_axi_bready_in : wr_go;
    bresp_nxt  = bresp_r;
    if (wr_go)
      bresp_nxt = (awaddr_r == RXDATA_OFS) ? RESP_SLVERR : RESP_OKAY;
    // Slots stay full until the answer is taken, so readies stay low
    if (b_r && s_axi_bready_in)
    begin
      aw_nxt = 1'b0;
      w_nxt  = 1'b0;
    end
    rd_rx     = s_axi_arvalid_in && !r_r && s_axi_araddr_in == RXDATA_OFS;
    r_nxt     = r_r ? !s_axi_rready_in : s_axi_arvalid_in;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (s_axi_arvalid_in && !r_r)
    begin
      rresp_nxt = RESP_OKAY;
      case (s_axi_araddr_in)
        MODE_OFS:   rdata_nxt = {16'h0000, mode_r};
        STATUS_OFS: rdata_nxt = {17'h00000, pol_r, 11'h000, framing_error_flag_r,
                                 1'b0, avail_r};
        RATE_OFS:   rdata_nxt = {16'h0000, rate_r};
        RXDATA_OFS: rdata_nxt = {24'h000000, rxdata_r};
        default:
        begin
          rdata_nxt = 32'h0000_0000;
          rresp_nxt = RESP_SLVERR;
        end
      endcase
    end
  end

  // Register file; hardware clears take effect unless software writes the mode register
  always_comb
  begin
    mode_nxt   = mode_r;
    rate_nxt   = hw_rate_ld ? hw_rate : rate_r;
    pol_nxt    = pol_r;
    framing_error_flag_nxt   = framing_error_flag_r;
    avail_nxt  = avail_r & ~rd_rx;
    rxdata_nxt = hw_avail ? shift_r : rxdata_r;
    if (hw_wake_clr)
      mode_nxt[MODE_WAKE_BIT] = 1'b0;
    if (hw_abd_clr)
      mode_nxt[MODE_ABD_BIT] = 1'b0;
    if (wr_go && s_axi_wstrb_in == 4'h0)
      mode_nxt = mode_nxt;
    if (wr_go)
    begin
      case (awaddr_r)
        MODE_OFS:   mode_nxt = wdata_r[15:0];
        RATE_OFS:   rate_nxt = wdata_r[15:0];
        STATUS_OFS:
        begin
          pol_nxt = wdata_r[STAT_POL_BIT];
          if (wdata_r[STAT_FRAMING_ERROR_FLAG_BIT])
            framing_error_flag_nxt = 1'b0;
        end
        default:    mode_nxt = mode_nxt;
      endcase
    end
    // Set wins over a clear in the same cycle
    if (hw_framing_error_flag_set)
      framing_error_flag_nxt = 1'b1;
    if (hw_avail)
      avail_nxt = 1'b1;
  end

  // All registers
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      mode_r <= MODE_RESET;  rate_r <= RATE_RESET;
      pol_r <= 1'b0;  framing_error_flag_r <= 1'b0;  avail_r <= 1'b0;
      rxdata_r <= 8'h00;
      aw_r <= 1'b0;  w_r <= 1'b0;  b_r <= 1'b0;  r_r <= 1'b0;
      awaddr_r <= 4'h0;  wdata_r <= 32'h0000_0000;
      rdata_r <= 32'h0000_0000;
      bresp_r <= RESP_OKAY;  rresp_r <= RESP_OKAY;
      div_r <= 16'h0000;  half_ph_r <= 1'b0;  bclk_r <= 1'b0;
      tx_ph_r <= 4'h0;  strobe_r <= 1'b0;  sout_r <= 1'b1;
      stream_q_r <= 1'b1;  rxs_r <= 1'b1;  wake_evt_r <= 1'b0;
      st_r <= RX_IDLE;  tcnt_r <= 4'h0;  bidx_r <= 3'h0;
      ones_r <= 2'h0;  shift_r <= 8'h00;  ecnt_r <= 3'h0;
      abd_r <= 24'h000000;
    end
    else
    begin
      mode_r <= mode_nxt;  rate_r <= rate_nxt;
      pol_r <= pol_nxt;  framing_error_flag_r <= framing_error_flag_nxt;  avail_r <= avail_nxt;
      rxdata_r <= rxdata_nxt;
      aw_r <= aw_nxt;  w_r <= w_nxt;  b_r <= b_nxt;  r_r <= r_nxt;
      awaddr_r <= awaddr_nxt;  wdata_r <= wdata_nxt;
      rdata_r <= rdata_nxt;
      bresp_r <= bresp_nxt;  rresp_r <= rresp_nxt;
      div_r <= div_nxt;  half_ph_r <= half_ph_nxt;  bclk_r <= bclk_nxt;
      tx_ph_r <= tx_ph_nxt;  strobe_r <= strobe_nxt;  sout_r <= sout_nxt;
      stream_q_r <= stream;  rxs_r <= stream;  wake_evt_r <= wake_evt_nxt;
      st_r <= st_nxt;  tcnt_r <= tcnt_nxt;  bidx_r <= bidx_nxt;
      ones_r <= ones_nxt;  shift_r <= shift_nxt;  ecnt_r <= ecnt_nxt;
      abd_r <= abd_nxt;
    end
  end

  // Ready is high only while the channel's holding slot is free
  assign s_axi_awready_out  = !aw_r;
  assign s_axi_wready_out   = !w_r;
  assign s_axi_arready_out  = !r_r;
  assign s_axi_bvalid_out   = b_r;
  assign s_axi_bresp_out    = bresp_r;
  assign s_axi_rvalid_out   = r_r;
  assign s_axi_rdata_out    = rdata_r;
  assign s_axi_rresp_out    = rresp_r;
  assign serial_out_pin_out = sout_r;
  assign baud_clock_out     = bclk_r;
  assign tx_bit_strobe_out  = strobe_r;
  assign rx_stream_out      = rxs_r;
  assign rx_wake_event_out  = wake_evt_r;

endmodule
`default_nettype wire

// >>> sim/uart_irlin_rx_monitor.sv
// Port-level checker for the infrared and LIN receive front end.
// Assumes the top module's ports only; bound after the module.
`timescale 1ns/1ns
`default_nettype none
module uart_irlin_rx_monitor
  import uart_irlin_pkg::*;
(
  input wire logic        clk_in,
  input wire logic        rstn_in,
  input wire logic        s_axi_awvalid_in,
  input wire logic        s_axi_awready_out,
  input wire logic        s_axi_wvalid_in,
  input wire logic        s_axi_wready_out,
  input wire logic        s_axi_bvalid_out,
  input wire logic        s_axi_arvalid_in,
  input wire logic        s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic [1:0]  s_axi_rresp_out,
  input wire logic        s_axi_rvalid_out,
  input wire logic        s_axi_rready_in,
  input wire logic        serial_out_pin_out,
  input wire logic        tx_bit_strobe_out,
  input wire logic        rx_stream_out,
  input wire logic        rx_wake_event_out
);
  default clocking cb @(posedge clk_in); endclocking

  // Both write channels taken at one edge
  sequence wr_taken;
    s_axi_awvalid_in && s_axi_awready_out &&
    s_axi_wvalid_in && s_axi_wready_out;
  endsequence
  sequence rd_taken;
    s_axi_arvalid_in && s_axi_arready_out;
  endsequence
  sequence wr_answer;
    !s_axi_awready_out && !s_axi_wready_out ##1 s_axi_bvalid_out;
  endsequence

  a_write_answer: assert property (disable iff (!rstn_in)
    wr_taken |=> wr_answer) else $error("write answer late");
  a_write_refused: assert property (disable iff (!rstn_in)
    s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
    else $error("write taken while answering");
  a_read_answer: assert property (disable iff (!rstn_in)
    rd_taken |=> s_axi_rvalid_out) else $error("read answer late");
  a_read_single: assert property (disable iff (!rstn_in)
    s_axi_rvalid_out && s_axi_rready_in |=> !s_axi_rvalid_out)
    else $error("read answered twice");
  a_slverr_zero: assert property (disable iff (!rstn_in)
    s_axi_rvalid_out && s_axi_rresp_out == RESP_SLVERR
    |-> s_axi_rdata_out == 32'h0) else $error("error read data");
  a_strobe_spacing: assert property (disable iff (!rstn_in)
    tx_bit_strobe_out |=> !tx_bit_strobe_out [*8])
    else $error("bit strobes too close");
  a_wake_pulse: assert property (disable iff (!rstn_in)
    rx_wake_event_out |=> !rx_wake_event_out)
    else $error("wake event too long");
  a_reset_idle: assert property (
    !rstn_in |=> s_axi_awready_out && s_axi_arready_out &&
    !s_axi_bvalid_out && serial_out_pin_out && rx_stream_out)
    else $error("outputs not idle after reset");
endmodule

bind uart_irlin_rx uart_irlin_rx_monitor mon (.clk_in, .rstn_in,
  .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wvalid_in,
  .s_axi_wready_out, .s_axi_bvalid_out, .s_axi_arvalid_in,
  .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out,
  .s_axi_rvalid_out, .s_axi_rready_in, .serial_out_pin_out,
  .tx_bit_strobe_out, .rx_stream_out, .rx_wake_event_out);
`default_nettype wire

// >>> sim/lin_ir_peer.sv
// Far-side line model: a LIN master node or an infrared transmitter.
// Assumes clk_in is the bench clock; the line idles high on a pull-up.
`timescale 1ns/1ns
`default_nettype none
module lin_ir_peer (
  input  wire logic clk_in,
  output logic      line_out
);
  initial line_out = 1'b1;

  // One bit time; an infrared zero is a short low pulse mid-bit
  task automatic send_bit(input logic b, input int bc, input logic ir);
    int i;
    for (i = 0; i < bc; i++)
    begin
      if (ir)
        line_out <= !(!b && i >= bc * 7 / 16 && i < bc * 10 / 16);
      else
        line_out <= b;
      @(posedge clk_in);
    end
  endtask

  // Start bit, eight bits first bit lowest, one stop bit
  task automatic send_byte(input logic [7:0] d, input int bc,
                           input logic ir);
    int i;
    send_bit(1'b0, bc, ir);
    for (i = 0; i < 8; i++)
      send_bit(d[i], bc, ir);
    send_bit(1'b1, bc, ir);
  endtask

  // Start bit plus twelve zeros, then the delimiter
  task automatic send_break(input int bc, input int delim);
    send_bit(1'b0, bc * 13, 1'b0);
    send_bit(1'b1, bc * delim, 1'b0);
  endtask
endmodule
`default_nettype wire

// >>> sim/test_uart_irlin_rx.sv
// Self-checking bench for the infrared and LIN receive front end.
// Assumes the line model on the serial input and this bench as bus master.
`timescale 1ns/1ns
`default_nettype none
module test_uart_irlin_rx;
  import uart_irlin_pkg::*;
  localparam logic [31:0] EN = 32'h1 << MODE_ENABLE_BIT;
  localparam logic [31:0] IR = 32'h1 << MODE_IRDA_BIT;
  localparam logic [31:0] WK = 32'h1 << MODE_WAKE_BIT;
  localparam logic [31:0] AB = 32'h1 << MODE_ABD_BIT;
  logic clk_in = 1'b0, rstn_in = 1'b0, tx_bit = 1'b1;
  logic aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0;
  logic [3:0] aw_a = 4'h0, ar_a = 4'h0;
  logic [31:0] w_d = 32'h0, rd, data;
  logic awr, wr, bv, arr, rv, sout, bclk, strb, rxs, wev, pin;
  logic [1:0] br, rr, resp;
  int mismatches = 0, n_checks = 0, wakes = 0;

  uart_irlin_rx uut (.clk_in, .rstn_in,
    .s_axi_awaddr_in(aw_a), .s_axi_awvalid_in(aw_v),
    .s_axi_awready_out(awr), .s_axi_wdata_in(w_d),
    .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(w_v), .s_axi_wready_out(wr),
    .s_axi_bresp_out(br), .s_axi_bvalid_out(bv), .s_axi_bready_in(b_r),
    .s_axi_araddr_in(ar_a), .s_axi_arvalid_in(ar_v),
    .s_axi_arready_out(arr), .s_axi_rdata_out(rd), .s_axi_rresp_out(rr),
    .s_axi_rvalid_out(rv), .s_axi_rready_in(r_r),
    .serial_in_pin_in(pin), .serial_out_pin_out(sout),
    .baud_clock_out(bclk), .tx_bit_in(tx_bit), .tx_bit_strobe_out(strb),
    .rx_stream_out(rxs), .rx_wake_event_out(wev));
  lin_ir_peer peer (.clk_in, .line_out(pin));

  // 50 ns clock and a count of wake events
  always #25 clk_in = ~clk_in;
  always @(posedge clk_in)
    if (wev === 1'b1) wakes <= wakes + 1;

  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, g);
    n_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_rng(input string n, input int lo, hi, g);
    n_checks++;
    if (g < lo || g > hi)
    begin
      mismatches++;
      $display("ERROR %s expected %0d..%0d seen %0d", n, lo, hi, g);
    end
  endtask
  task automatic tmo(input string n);
    mismatches++;
    $display("ERROR %s expected answer seen timeout", n);
    results();
  endtask

  // Bus cycles: ready lowered, then one edge passes before the next
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    int i;
    aw_a <= a; w_d <= d; aw_v <= 1'b1; w_v <= 1'b1; b_r <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge clk_in);
      if (awr === 1'b1) aw_v <= 1'b0;
      if (wr === 1'b1) w_v <= 1'b0;
      if (bv === 1'b1) break;
    end
    if (i == 50) tmo("write");
    resp = br; b_r <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic axi_rd(input logic [3:0] a);
    int i;
    ar_a <= a; ar_v <= 1'b1; r_r <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge clk_in);
      if (arr === 1'b1) ar_v <= 1'b0;
      if (rv === 1'b1) break;
    end
    if (i == 50) tmo("read");
    data = rd; resp = rr; r_r <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic wait_strb;
    int i;
    for (i = 0; i < 200 && strb !== 1'b1; i++)
      @(posedge clk_in);
    if (i == 200) tmo("bit strobe");
    @(posedge clk_in);
  endtask
  // Counts output highs and clock-out toggles over n cycles
  task automatic sample(input int n, output int h, t);
    logic p;
    p = bclk; h = 0; t = 0;
    repeat (n)
    begin
      @(posedge clk_in);
      h += (sout === 1'b1);
      t += (bclk !== p);
      p = bclk;
    end
  endtask
  // Highs in one 32-clock bit, divider at zero
  function automatic int exp_hi(input logic c, p, b);
    int h;
    if (!c) return b ? 32 : 0;
    h = b ? 0 : 6;
    return p ? 32 - h : h;
  endfunction
  function automatic logic [31:0] exp_rate(input int clks);
    return 32'((clks >> 8) - 1);
  endfunction

  // Main sequence
  initial
  begin
    int k, m, h, t, w0;
    logic [7:0] b;
    void'($urandom(22));
    repeat (5) @(posedge clk_in);
    rstn_in <= 1'b1;
    axi_rd(MODE_OFS);
    chk("mode reset", 32'(MODE_RESET), data);
    axi_rd(RATE_OFS);
    chk("rate reset", 32'(RATE_RESET), data);
    w0 = $urandom;
    axi_wr(RATE_OFS, w0);
    chk("write resp", 32'(RESP_OKAY), 32'(resp));
    axi_rd(RATE_OFS);
    chk("rate rw", {16'h0, w0[15:0]}, data);
    chk("read resp", 32'(RESP_OKAY), 32'(resp));
    axi_rd(4'h2);
    chk("unmapped resp", 32'(RESP_SLVERR), 32'(resp));
    chk("unmapped data", 32'h0, data);
    axi_wr(RXDATA_OFS, 32'hFF);
    chk("ro write resp", 32'(RESP_SLVERR), 32'(resp));
    axi_wr(RATE_OFS, 32'h0);
    axi_wr(MODE_OFS, EN | (32'h3 << MODE_PINS_LO));
    sample(64, h, t);
    chk_rng("clock out toggles", 63, 64, t);
    axi_wr(MODE_OFS, EN | (32'h2 << MODE_PINS_LO));
    sample(64, h, t);
    chk_rng("clock out idle", 0, 0, t);
    // Transmit pin highs for each infrared, polarity and bit setting
    for (k = 0; k < 8; k++)
    begin
      axi_wr(MODE_OFS, EN | (k[2] ? IR : 32'h0));
      axi_wr(STATUS_OFS, 32'(k[1]) << STAT_POL_BIT);
      tx_bit <= k[0];
      wait_strb();
      wait_strb();
      sample(32, h, t);
      chk_rng("tx highs", exp_hi(k[2], k[1], k[0]),
              exp_hi(k[2], k[1], k[0]), h);
    end
    // Receive in raw and infrared mode: zeros, sync pattern, random
    for (m = 0; m < 2; m++)
      for (k = 0; k < 3; k++)
      begin
        b = (k == 0) ? 8'h00 : (k == 1) ? 8'h55 : 8'($urandom);
        axi_wr(MODE_OFS, EN | (m[0] ? IR : 32'h0));
        peer.send_byte(b, 32, m[0]);
        repeat (64) @(posedge clk_in);
        axi_rd(STATUS_OFS);
        chk("rx avail", 32'h1, 32'(data[STAT_AVAIL_BIT]));
        axi_rd(RXDATA_OFS);
        chk("rx byte", {24'h0, b}, data);
      end
    // Lone infrared pulse: lag from bit start and stretched low
    h = 0;
    t = 0;
    fork
      peer.send_bit(1'b0, 32, 1'b1);
      begin
        while (h < 40 && rxs !== 1'b0)
        begin
          @(posedge clk_in);
          h++;
        end
        while (t < 60 && rxs === 1'b0)
        begin
          @(posedge clk_in);
          t++;
        end
      end
    join
    chk_rng("decode lag", 14, 19, h);
    chk_rng("decode low", 31, 33, t);
    repeat (400) @(posedge clk_in);
    axi_rd(RXDATA_OFS);
    // LIN frame, wake armed before auto rate on the first pass only; preload near the rate
    for (m = 0; m < 2; m++)
    begin
      axi_wr(MODE_OFS, EN);
      axi_wr(STATUS_OFS, 32'h1 << STAT_FRAMING_ERROR_FLAG_BIT);
      axi_wr(RATE_OFS, 32'h2);
      if (m == 0) axi_wr(MODE_OFS, EN | WK);
      axi_wr(MODE_OFS, EN | (m == 0 ? WK : 32'h0) | AB);
      w0 = wakes;
      peer.send_break(136, m == 0 ? 1 : 4);
      peer.send_byte(8'h55, 136, 1'b0);
      repeat (300) @(posedge clk_in);
      // Error status first; without wake the break is only measured
      axi_rd(STATUS_OFS);
      chk("break framing_error_flag", m == 0 ? 32'h1 : 32'h0,
          32'(data[STAT_FRAMING_ERROR_FLAG_BIT]));
      axi_rd(RATE_OFS);
      chk("measured rate", exp_rate((m == 0 ? 8 : 11) * 136),
          data);
      axi_rd(MODE_OFS);
      chk("mode after sync", EN, data);
      chk("wake events", m == 0 ? 32'h1 : 32'h0, 32'(wakes - w0));
    end
    results();
  end
endmodule
`default_nettype wire
